// ### rtl/fnh_ctrl.sv
// Host sequencer driving an asynchronous parallel NOR flash.
// Assumes dq_in comes from the pins; everything else is on clk.
`timescale 1ns/1ps
`include "fnh_consts.svh"

// Notes on behaviour
// - Status reads use the operation's address
// - Wait recovery time before first read
// - Reissue interrupted program or erase after reset
// - Unlock prefix; erase uses six cycles
// - Upper data byte driven valid in commands
// - 98H at 555H enters query table
// - Security program completion by toggle only
// - 88H at 555H enters security identifier
module fnh_ctrl #(
  parameter int WP_CYC = `FNH_WP_CYC,
  parameter int RC_CYC = `FNH_RC_CYC,
  parameter int RP_CYC = `FNH_RP_CYC,
  parameter int RHR_CYC = `FNH_RHR_CYC,
  parameter int POLL_LIMIT = `FNH_POLL_LIMIT,
  parameter bit BOOT_TOP = 1'b0
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic clk_en,
  input wire logic cmd_valid,
  input wire fnh_pkg::fnh_op_t cmd_op,
  input wire logic [21:0] cmd_addr,
  input wire logic [15:0] cmd_data,
  input wire logic guard_en,
  input wire logic [15:0] dq_in,
  output fnh_pkg::fnh_pins_t pins,
  output logic busy,
  output logic done,
  output logic error,
  output logic [15:0] rd_data,
  output fnh_pkg::fnh_mode_t mode
);
  fnh_pkg::fnh_state_t state_reg, state_next; // Sequencer
  fnh_pkg::fnh_op_t op_reg, op_next; // Order in flight
  logic [21:0] addr_reg, addr_next; // Order address
  logic [15:0] data_reg, data_next; // Order data
  logic [2:0] step_reg, step_next; // Write cycle index
  logic [15:0] cnt_reg, cnt_next; // Phase timer
  logic [19:0] poll_reg, poll_next; // Status reads so far
  logic tog_reg, tog_next; // Last toggle bit seen
  logic togv_reg, togv_next; // Toggle sample held
  logic polling_reg, polling_next; // Reads are status reads
  logic pend_reg, pend_next; // Program/erase running
  logic lock_reg, lock_next; // User segment locked
  logic wp_reg; // Guard pin level
  fnh_pkg::fnh_mode_t mode_reg, mode_next;
  logic [15:0] rd_reg, rd_next;
  logic done_next, err_next;
  logic [15:0] dq_s1, dq_s2; // Pin synchroniser
  fnh_pkg::fnh_pins_t pins_reg, pins_next;

  // Bus word for a given cycle of an order
  function automatic fnh_pkg::fnh_bus_t seq_word(
      input fnh_pkg::fnh_op_t op, input logic [2:0] idx,
      input logic [21:0] a, input logic [15:0] d);
    fnh_pkg::fnh_bus_t w;
    logic er;
    w = '{addr: `FNH_A555, data: `FNH_D_AA};
    er = op inside {fnh_pkg::OP_SERASE, fnh_pkg::OP_BERASE,
                    fnh_pkg::OP_CERASE};
    unique case (idx)
      3'h0: begin
        // Single-cycle orders carry their code at once
        if (op == fnh_pkg::OP_SUSP) w = '{a, `FNH_C_SUSP};
        else if (op == fnh_pkg::OP_RESUME) w = '{a, `FNH_C_RESUME};
        else if (op == fnh_pkg::OP_EXIT) w = '{a, `FNH_C_EXIT};
      end
      3'h1, 3'h4: w = '{`FNH_A2AA, `FNH_D_55};
      3'h2: begin
        unique case (op)
          fnh_pkg::OP_PROG: w.data = `FNH_C_PROG;
          fnh_pkg::OP_IDENT: w.data = `FNH_C_IDENT;
          fnh_pkg::OP_QUERY: w.data = `FNH_C_QUERY;
          fnh_pkg::OP_SECID: w.data = `FNH_C_SECID;
          fnh_pkg::OP_SPROG: w.data = `FNH_C_SPROG;
          fnh_pkg::OP_SLOCK: w.data = `FNH_C_SLOCK;
          default: w.data = `FNH_C_ERASE;
        endcase
      end
      // Program data or second unlock of erase
      3'h3: if (!er) w = '{a, (op == fnh_pkg::OP_SLOCK) ? 16'h0000 : d};
      default: begin
        if (op == fnh_pkg::OP_SERASE) w = '{a, `FNH_C_SECT};
        else if (op == fnh_pkg::OP_BERASE) w = '{a, `FNH_C_BLOCK};
        else w.data = `FNH_C_CHIP;
      end
    endcase
    return w;
  endfunction

  // Order decode
  wire is_erase = op_next inside {fnh_pkg::OP_SERASE,
    fnh_pkg::OP_BERASE, fnh_pkg::OP_CERASE};
  wire is_single = op_next inside {fnh_pkg::OP_SUSP,
    fnh_pkg::OP_RESUME, fnh_pkg::OP_EXIT};
  wire is_prog = op_next inside {fnh_pkg::OP_PROG, fnh_pkg::OP_SPROG,
    fnh_pkg::OP_SLOCK};
  // Erase has six cycles, program four, entries three
  wire [2:0] last_step = is_erase ? 3'h5 : is_prog ? 3'h3 :
    is_single ? 3'h0 : 3'h2;
  // Orders whose end is found by status reads
  wire needs_poll = is_erase | is_prog | (op_next == fnh_pkg::OP_SUSP);
  wire in_boot = BOOT_TOP ? (cmd_addr >= `FNH_BOOT_TOP_LO) :
    (cmd_addr <= `FNH_BOOT_BOT_HI);
  // Host never sends what the device would refuse
  wire refuse = (!wp_reg && ((cmd_op == fnh_pkg::OP_CERASE) ||
    (in_boot && cmd_op inside {fnh_pkg::OP_PROG, fnh_pkg::OP_SERASE,
    fnh_pkg::OP_BERASE}))) ||
    (lock_reg && cmd_op == fnh_pkg::OP_SPROG);
  wire fnh_pkg::fnh_bus_t word = seq_word(op_next, step_next,
    addr_next, data_next);
  wire [15:0] rc_end = 16'(RC_CYC + 1); // Access time plus synchroniser

  // Next-state logic
  always_comb begin
    state_next = state_reg;
    op_next = op_reg;
    addr_next = addr_reg;
    data_next = data_reg;
    step_next = step_reg;
    cnt_next = cnt_reg + 16'h0001;
    poll_next = poll_reg;
    tog_next = tog_reg;
    togv_next = togv_reg;
    polling_next = polling_reg;
    pend_next = pend_reg;
    lock_next = lock_reg;
    mode_next = mode_reg;
    rd_next = rd_reg;
    done_next = 1'b0;
    err_next = 1'b0;
    unique case (state_reg)
      fnh_pkg::ST_IDLE: begin
        cnt_next = 16'h0000;
        step_next = 3'h0;
        if (cmd_valid) begin
          // Reset keeps the order in flight so it can be reissued
          if (cmd_op == fnh_pkg::OP_RESET) state_next = fnh_pkg::ST_RSTLO;
          else begin
            op_next = cmd_op;
            addr_next = cmd_addr;
            data_next = cmd_data;
            if (refuse) begin
              done_next = 1'b1;
              err_next = 1'b1;
            end else if (cmd_op == fnh_pkg::OP_READ) begin
              state_next = fnh_pkg::ST_RLOW;
            end else begin
              // Exit only goes out here, never during a program or erase
              state_next = fnh_pkg::ST_WLOW;
            end
          end
        end
      end
      fnh_pkg::ST_WLOW: begin
        // Strobe held for whole cycles, far above glitch width
        if (cnt_reg >= 16'(WP_CYC - 1)) begin
          state_next = fnh_pkg::ST_WHIGH;
          cnt_next = 16'h0000;
        end
      end
      fnh_pkg::ST_WHIGH: begin
        cnt_next = 16'h0000;
        if (step_reg != last_step) begin
          step_next = step_reg + 3'h1;
          state_next = fnh_pkg::ST_WLOW;
        end else if (needs_poll) begin
          // Status valid once the final pulse has risen
          state_next = fnh_pkg::ST_RLOW;
          polling_next = 1'b1;
          togv_next = 1'b0;
          poll_next = 20'h00000;
          pend_next = is_erase | (op_reg inside {fnh_pkg::OP_PROG,
            fnh_pkg::OP_SPROG});
          if (op_reg == fnh_pkg::OP_SLOCK) lock_next = 1'b1;
        end else begin
          state_next = fnh_pkg::ST_IDLE;
          done_next = 1'b1;
          // Mode follows completed sequences only
          unique case (op_reg)
            fnh_pkg::OP_IDENT: mode_next = fnh_pkg::MODE_IDENT;
            fnh_pkg::OP_QUERY: mode_next = fnh_pkg::MODE_QUERY;
            fnh_pkg::OP_SECID: mode_next = fnh_pkg::MODE_SECID;
            fnh_pkg::OP_EXIT: mode_next = fnh_pkg::MODE_ARRAY;
            default: mode_next = mode_reg;
          endcase
        end
      end
      fnh_pkg::ST_RLOW: begin
        if (cnt_reg >= rc_end) begin
          state_next = fnh_pkg::ST_RHIGH;
          cnt_next = 16'h0000;
          rd_next = dq_s2;
          poll_next = poll_reg + 20'h00001;
        end
      end
      fnh_pkg::ST_RHIGH: begin
        cnt_next = 16'h0000;
        // Keep this read's toggle bit to compare with the next one
        tog_next = rd_reg[`FNH_TOG_BIT];
        togv_next = 1'b1;
        if (!polling_reg) begin
          state_next = fnh_pkg::ST_IDLE;
          done_next = 1'b1;
        // Only the toggle bit decides; polling bit is unreliable
        // for security programs and suspended sectors
        end else if (togv_reg && poll_reg > 20'h00001 &&
            rd_reg[`FNH_TOG_BIT] == tog_reg) begin
          state_next = fnh_pkg::ST_IDLE;
          done_next = 1'b1;
          polling_next = 1'b0;
          pend_next = 1'b0;
        end else if (poll_reg >= 20'(POLL_LIMIT)) begin
          state_next = fnh_pkg::ST_IDLE;
          done_next = 1'b1;
          err_next = 1'b1;
          polling_next = 1'b0;
        end else state_next = fnh_pkg::ST_RLOW;
      end
      fnh_pkg::ST_RSTLO: begin
        if (cnt_reg >= 16'(RP_CYC - 1)) begin
          state_next = fnh_pkg::ST_RSTREC;
          cnt_next = 16'h0000;
          mode_next = fnh_pkg::MODE_ARRAY;
          polling_next = 1'b0;
        end
      end
      fnh_pkg::ST_RSTREC: begin
        if (cnt_reg >= 16'(RHR_CYC - 1)) begin
          cnt_next = 16'h0000;
          step_next = 3'h0;
          // Interrupted work is started again from its prefix
          if (pend_reg) state_next = fnh_pkg::ST_WLOW;
          else begin
            state_next = fnh_pkg::ST_IDLE;
            done_next = 1'b1;
          end
        end
      end
      default: state_next = fnh_pkg::ST_IDLE;
    endcase
  end

  // Pin values for the coming state
  wire wr_next = state_next == fnh_pkg::ST_WLOW;
  wire rd_go = state_next == fnh_pkg::ST_RLOW;
  always_comb begin
    pins_next.ce_n = !(wr_next | rd_go);
    pins_next.we_n = !wr_next;
    pins_next.oe_n = !rd_go;
    pins_next.rst_n = state_next != fnh_pkg::ST_RSTLO;
    pins_next.wp_n = wp_reg;
    pins_next.dq_oe = wr_next;
    // Poll at the address of the running order
    pins_next.addr = wr_next ? word.addr : addr_next;
    pins_next.dq = wr_next ? {8'h00, word.data[7:0]} : 16'h0000;
  end

  // Two-flop synchroniser on the data pins
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      dq_s1 <= 16'h0000;
      dq_s2 <= 16'h0000;
    end else if (clk_en) begin
      dq_s1 <= dq_in;
      dq_s2 <= dq_s1;
    end
  end

  // Guard pin changes only between orders, never mid-sequence
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) wp_reg <= 1'b1;
    else if (clk_en && state_reg == fnh_pkg::ST_IDLE && !cmd_valid)
      wp_reg <= !guard_en;
  end

  // State registers
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= fnh_pkg::ST_IDLE;
      op_reg <= fnh_pkg::OP_READ;
      addr_reg <= 22'h000000;
      data_reg <= 16'h0000;
      step_reg <= 3'h0;
      cnt_reg <= 16'h0000;
      poll_reg <= 20'h00000;
      {tog_reg, togv_reg, polling_reg, pend_reg, lock_reg} <= 5'h00;
      mode_reg <= fnh_pkg::MODE_ARRAY;
      rd_reg <= 16'h0000;
      {done, error, busy} <= 3'h0;
      pins_reg <= {6'h3E, 22'h000000, 16'h0000};
    end else if (clk_en) begin
      state_reg <= state_next;
      op_reg <= op_next;
      addr_reg <= addr_next;
      data_reg <= data_next;
      step_reg <= step_next;
      cnt_reg <= cnt_next;
      poll_reg <= poll_next;
      {tog_reg, togv_reg, polling_reg} <= {tog_next, togv_next,
        polling_next};
      {pend_reg, lock_reg} <= {pend_next, lock_next};
      mode_reg <= mode_next;
      rd_reg <= rd_next;
      {done, error} <= {done_next, err_next};
      busy <= state_next != fnh_pkg::ST_IDLE;
      pins_reg <= pins_next;
    end
  end

  assign pins = pins_reg;
  assign rd_data = rd_reg;
  assign mode = mode_reg;

  // Helper counters for the reset timing checks
  logic [15:0] rlo_reg, rel_reg;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rlo_reg <= 16'h0000;
      rel_reg <= 16'hFFFF;
    end else if (clk_en) begin
      rlo_reg <= pins_reg.rst_n ? 16'h0000 : rlo_reg + 16'h0001;
      rel_reg <= !pins_reg.rst_n ? 16'h0000 :
        (rel_reg == 16'hFFFF) ? rel_reg : rel_reg + 16'h0001;
    end
  end

  a_wr_gate_excl: assert property (@(posedge clk) disable iff (!rst_n)
    !pins.we_n |-> pins.oe_n && !pins.ce_n && pins.dq_oe)
    else $error("write strobe low with output gate low");
  a_strobe_width: assert property (@(posedge clk) disable iff (!rst_n)
    $rose(pins.we_n) |-> $past(cnt_reg) >= 16'(WP_CYC - 1))
    else $error("write strobe pulse too short");
  a_upper_byte: assert property (@(posedge clk) disable iff (!rst_n)
    !pins.we_n |-> pins.dq[15:8] == 8'h00)
    else $error("upper data byte not driven low");
  a_prefix_first: assert property (@(posedge clk) disable iff (!rst_n)
    !pins.we_n && step_reg == 3'h0 && !is_single |->
      pins.addr == `FNH_A555 && pins.dq == `FNH_D_AA)
    else $error("unlock prefix first cycle wrong");
  a_query_code: assert property (@(posedge clk) disable iff (!rst_n)
    !pins.we_n && step_reg == 3'h2 && op_reg == fnh_pkg::OP_QUERY |->
      pins.addr == `FNH_A555 && pins.dq == `FNH_C_QUERY)
    else $error("query entry code wrong");
  a_secid_code: assert property (@(posedge clk) disable iff (!rst_n)
    !pins.we_n && step_reg == 3'h2 && op_reg == fnh_pkg::OP_SECID |->
      pins.addr == `FNH_A555 && pins.dq == `FNH_C_SECID)
    else $error("security entry code wrong");
  a_rst_pulse: assert property (@(posedge clk) disable iff (!rst_n)
    $rose(pins.rst_n) |-> $past(rlo_reg) >= 16'(RP_CYC - 1))
    else $error("reset pulse shorter than minimum");
  a_rst_recover: assert property (@(posedge clk) disable iff (!rst_n)
    $fell(pins.oe_n) |-> rel_reg >= 16'(RHR_CYC))
    else $error("read before reset recovery");
  a_poll_addr: assert property (@(posedge clk) disable iff (!rst_n)
    !pins.oe_n && polling_reg |-> pins.addr == addr_reg)
    else $error("status read at wrong address");
  a_boot_guard: assert property (@(posedge clk) disable iff (!rst_n)
    !pins.we_n && !pins.wp_n && step_reg == last_step &&
      (is_erase || op_reg == fnh_pkg::OP_PROG) |->
      op_reg != fnh_pkg::OP_CERASE && (BOOT_TOP ?
      addr_reg < `FNH_BOOT_TOP_LO : addr_reg > `FNH_BOOT_BOT_HI))
    else $error("boot block write sent under write guard");
  c_erase_done: cover property (@(posedge clk) disable iff (!rst_n)
    done && !error && op_reg == fnh_pkg::OP_SERASE);
  c_ident_read: cover property (@(posedge clk) disable iff (!rst_n)
    done && op_reg == fnh_pkg::OP_READ && mode == fnh_pkg::MODE_IDENT);
  c_reissue: cover property (@(posedge clk) disable iff (!rst_n)
    state_reg == fnh_pkg::ST_RSTREC ##1 state_reg == fnh_pkg::ST_WLOW);
endmodule

// ### rtl/fnh_consts.svh
// Constants for the parallel NOR flash host controller.
// Assumes a 20 MHz system clock; all times are in ns.
`ifndef FNH_CONSTS_SVH
`define FNH_CONSTS_SVH
`define FNH_ADDR_W 22
`define FNH_A555 22'h000555
`define FNH_A2AA 22'h0002AA
`define FNH_D_AA 16'h00AA
`define FNH_D_55 16'h0055
`define FNH_C_PROG 16'h00A0
`define FNH_C_ERASE 16'h0080
`define FNH_C_SECT 16'h0050
`define FNH_C_BLOCK 16'h0030
`define FNH_C_CHIP 16'h0010
`define FNH_C_SUSP 16'h00B0
`define FNH_C_RESUME 16'h0030
`define FNH_C_IDENT 16'h0090
`define FNH_C_QUERY 16'h0098
`define FNH_C_SECID 16'h0088
`define FNH_C_SPROG 16'h00A5
`define FNH_C_SLOCK 16'h0085
`define FNH_C_EXIT 16'h00F0
`define FNH_BOOT_BOT_HI 22'h007FFF
`define FNH_BOOT_TOP_LO 22'h3F8000
`define FNH_TOG_BIT 6
`define FNH_T_CLK_NS 50
`define FNH_T_GLITCH_NS 5
`define FNH_T_WP_NS 40
`define FNH_READ_NS 70
`define FNH_RST_PULSE_NS 500
`define FNH_RST_RECOVER_NS 50000
// Least times round up
`define FNH_WP_CYC ((`FNH_T_WP_NS + `FNH_T_CLK_NS - 1) / `FNH_T_CLK_NS)
`define FNH_RC_CYC ((`FNH_READ_NS + `FNH_T_CLK_NS - 1) / `FNH_T_CLK_NS)
`define FNH_RP_CYC ((`FNH_RST_PULSE_NS + `FNH_T_CLK_NS - 1) / `FNH_T_CLK_NS)
`define FNH_RHR_CYC \
  ((`FNH_RST_RECOVER_NS + `FNH_T_CLK_NS - 1) / `FNH_T_CLK_NS)
`define FNH_POLL_LIMIT 1000000
`endif

// ### rtl/fnh_pkg.sv
// Types for the parallel NOR flash host controller.
// Shared by the controller and its bench.
package fnh_pkg;
  // User orders
  typedef enum logic [3:0] {
    OP_READ, OP_PROG, OP_SERASE, OP_BERASE, OP_CERASE, OP_SUSP,
    OP_RESUME, OP_IDENT, OP_QUERY, OP_SECID, OP_EXIT, OP_SPROG,
    OP_SLOCK, OP_RESET
  } fnh_op_t;
  // Sequencer states, one-hot
  typedef enum logic [6:0] {
    ST_IDLE = 7'h01, ST_WLOW = 7'h02, ST_WHIGH = 7'h04, ST_RLOW = 7'h08,
    ST_RHIGH = 7'h10, ST_RSTLO = 7'h20, ST_RSTREC = 7'h40
  } fnh_state_t;
  // Device mode as tracked by the host
  typedef enum logic [1:0] {
    MODE_ARRAY = 2'h0, MODE_IDENT = 2'h1, MODE_QUERY = 2'h2,
    MODE_SECID = 2'h3
  } fnh_mode_t;
  // One bus write cycle
  typedef struct packed {
    logic [21:0] addr;
    logic [15:0] data;
  } fnh_bus_t;
  // Flash pin outputs
  typedef struct packed {
    logic ce_n;
    logic oe_n;
    logic we_n;
    logic rst_n;
    logic wp_n;
    logic dq_oe;
    logic [21:0] addr;
    logic [15:0] dq;
  } fnh_pins_t;
endpackage

// ### verif/fnh_flash_model.sv
// Behavioural model of the parallel NOR flash seen by the host controller.
// Assumes the controller's registered pin struct; no clock of its own.
`timescale 1ns/1ps

module fnh_flash_model #(
  parameter logic [15:0] MFR_CODE = 16'h00C3, // Arbitrary value
  parameter logic [15:0] DEV_CODE = 16'h7A11, // Arbitrary value
  parameter bit BOOT_TOP = 1'b0,
  parameter int PROG_READS = 3, // Status reads while a program runs
  parameter int ERASE_READS = 5 // Status reads while an erase runs
) (
  input fnh_pkg::fnh_pins_t pins,
  output logic [15:0] dq_out,
  output logic [15:0] prog_cnt,
  output logic [15:0] erase_cnt,
  output logic [15:0] wr_cnt,
  output logic [15:0] rst_cnt,
  output fnh_pkg::fnh_mode_t dev_mode
);
  logic [15:0] mem [logic [21:0]]; // Sparse array contents
  logic [15:0] rd_val = 16'h0000; // Value shown while read gated
  logic [15:0] la_d, last_d = 16'h0000, sec_d = 16'hFFFF;
  logic [21:0] la_a, op_a = 22'h000000;
  int step = 0; // Position inside an unlock sequence
  int busy_rd = 0; // Status reads left before completion
  logic erasing = 1'b0, tog = 1'b0, tog2 = 1'b0, locked = 1'b0;
  logic la_ok = 1'b0, susp = 1'b0;
  realtime t_fall = 0.0;

  initial begin
    prog_cnt = 16'h0000;
    erase_cnt = 16'h0000;
    wr_cnt = 16'h0000;
    rst_cnt = 16'h0000;
    dev_mode = fnh_pkg::MODE_ARRAY;
  end

  // Released bus shows the inverse so a stale value never passes
  assign dq_out = (!pins.ce_n && !pins.oe_n) ? rd_val : ~rd_val;

  // Boot block under hardware guard
  function automatic bit guarded(input logic [21:0] a);
    guarded = !pins.wp_n && (BOOT_TOP ? (a >= 22'h3F8000) :
      (a <= 22'h007FFF));
  endfunction

  // Address and data latched as the strobe falls
  always @(negedge pins.we_n) begin
    la_ok = !pins.ce_n && pins.oe_n;
    la_a = pins.addr;
    la_d = pins.dq;
    t_fall = $realtime;
  end

  // Short glitches and writes during a busy operation are dropped
  always @(posedge pins.we_n) begin
    if (la_ok && pins.rst_n && ($realtime - t_fall) >= 5.0 &&
        busy_rd == 0) begin
      take_write(la_a, la_d);
    end
  end

  // Command decoder; any wrong cycle returns to the first step, mode unchanged
  task automatic take_write(input logic [21:0] a, input logic [15:0] d);
    wr_cnt++;
    case (step)
      0: begin
        if (a[10:0] == 11'h555 && d[7:0] == 8'hAA) step = 1;
        else if (d[7:0] == 8'hF0) dev_mode = fnh_pkg::MODE_ARRAY;
        else if (d[7:0] == 8'hB0) susp = 1'b1;
        else if (d[7:0] == 8'h30) susp = 1'b0;
      end
      1: step = (a[10:0] == 11'h2AA && d[7:0] == 8'h55) ? 2 : 0;
      2: begin
        step = 0;
        if (a[10:0] == 11'h555) begin
          case (d[7:0])
            8'hA0: step = 6;
            8'h80: step = 3;
            8'hA5: step = 7;
            8'h85: step = 8;
            8'h90: dev_mode = fnh_pkg::MODE_IDENT;
            8'h98: dev_mode = fnh_pkg::MODE_QUERY;
            8'h88: dev_mode = fnh_pkg::MODE_SECID;
            8'hF0: dev_mode = fnh_pkg::MODE_ARRAY;
            default: step = 0;
          endcase
        end
      end
      3: step = (a[10:0] == 11'h555 && d[7:0] == 8'hAA) ? 4 : 0;
      4: step = (a[10:0] == 11'h2AA && d[7:0] == 8'h55) ? 5 : 0;
      5: begin
        step = 0;
        if ((d[7:0] == 8'h50 || d[7:0] == 8'h30 || d[7:0] == 8'h10) &&
            !(!pins.wp_n && d[7:0] == 8'h10) && !guarded(a)) begin
          erasing = 1'b1;
          busy_rd = ERASE_READS;
          erase_cnt++;
          op_a = a;
        end
      end
      6: begin
        step = 0;
        if (!guarded(a)) begin
          mem[a] = d;
          last_d = d;
          erasing = 1'b0;
          busy_rd = PROG_READS;
          prog_cnt++;
          op_a = a;
        end
      end
      7: begin
        step = 0;
        if (!locked) begin
          sec_d = d;
          last_d = d;
          erasing = 1'b0;
          busy_rd = PROG_READS;
        end
      end
      default: begin
        step = 0;
        locked = 1'b1;
        last_d = 16'h0000;
        busy_rd = PROG_READS;
      end
    endcase
  endtask

  // Each read access flips the toggle state while busy
  always @(negedge pins.oe_n) begin
    if (!pins.ce_n) begin
      if (busy_rd > 0) begin
        tog = ~tog;
        busy_rd--;
        if (erasing) rd_val = {8'h00, 1'b0, tog, 3'b000, tog, 2'b00};
        else rd_val = {8'h00, ~last_d[7], tog, 6'h00};
      end else if (susp && pins.addr == op_a) begin
        tog2 = ~tog2;
        rd_val = {8'h00, 1'b1, 1'b1, 3'b000, tog2, 2'b00};
      end else begin
        case (dev_mode)
          fnh_pkg::MODE_IDENT: rd_val = (pins.addr == 22'h000000) ?
            MFR_CODE : ((pins.addr == 22'h000001) ? DEV_CODE : 16'h0000);
          fnh_pkg::MODE_SECID: rd_val = sec_d;
          default: rd_val = mem.exists(pins.addr) ? mem[pins.addr] : 16'hFFFF;
        endcase
      end
    end
  end

  // Hard reset ends all activity and returns to array read
  always @(negedge pins.rst_n) begin
    step = 0;
    busy_rd = 0;
    susp = 1'b0;
    dev_mode = fnh_pkg::MODE_ARRAY;
    rst_cnt++;
  end
endmodule

// ### verif/flash_status_protect_id_modes_bench.sv
// Self-checking bench for the NOR flash host controller.
// Assumes fnh_ctrl and the flash model; shortened recovery and poll limit.
`timescale 1ns/1ps

module flash_status_protect_id_modes_bench;
  logic clk, rst_n, cmd_valid, guard_en, busy, done, error, err_s;
  fnh_pkg::fnh_op_t cmd_op;
  logic [21:0] cmd_addr;
  logic [15:0] cmd_data, dq_in, rd_data, dev_dq, rd_s, w0;
  logic [15:0] prog_cnt, erase_cnt, wr_cnt, rst_cnt;
  fnh_pkg::fnh_pins_t pins;
  fnh_pkg::fnh_mode_t mode, dev_mode;
  int n_errors = 0;
  int cmp_count = 0;

  // Data wire: host wins while it drives, else the flash
  assign dq_in = pins.dq_oe ? pins.dq : dev_dq;

  // 20 MHz clock
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  fnh_ctrl #(.RHR_CYC(4), .POLL_LIMIT(20)) u_fnh_ctrl (
    .clk(clk), .rst_n(rst_n), .clk_en(1'b1), .cmd_valid(cmd_valid),
    .cmd_op(cmd_op), .cmd_addr(cmd_addr), .cmd_data(cmd_data),
    .guard_en(guard_en), .dq_in(dq_in), .pins(pins), .busy(busy),
    .done(done), .error(error), .rd_data(rd_data), .mode(mode)
  );

  fnh_flash_model u_fnh_flash_model (
    .pins(pins), .dq_out(dev_dq), .prog_cnt(prog_cnt),
    .erase_cnt(erase_cnt), .wr_cnt(wr_cnt), .rst_cnt(rst_cnt),
    .dev_mode(dev_mode)
  );

  // Value comparison with mismatch report
  task automatic chk(input string what, input logic [15:0] exp,
      input logic [15:0] got);
    cmp_count++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask

  // One order: present for one edge, then wait for done, bounded
  task automatic run(input fnh_pkg::fnh_op_t op, input logic [21:0] a,
      input logic [15:0] d);
    int i;
    @(posedge clk);
    cmd_valid <= 1'b1;
    cmd_op <= op;
    cmd_addr <= a;
    cmd_data <= d;
    @(posedge clk);
    cmd_valid <= 1'b0;
    // A refused order answers at the very edge that takes it
    for (i = 0; i < 3000; i++) begin
      #1;
      if (done === 1'b1) break;
      @(posedge clk);
    end
    err_s = error;
    rd_s = rd_data;
    chk("order done", 16'h0001, {15'h0, done});
    chk("busy at done", 16'h0000, {15'h0, busy});
  endtask

  // Verdict in one place
  task automatic wrap_up;
    $display("compares %0d mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // Hang guard, far beyond the expected few hundred cycles
  initial begin
    repeat (20000) @(posedge clk);
    n_errors++;
    $display("BAD watchdog expected finish seen hang");
    wrap_up();
  end

  // Main sequence
  initial begin
    rst_n = 1'b0;
    cmd_valid = 1'b0;
    cmd_op = fnh_pkg::OP_READ;
    cmd_addr = 22'h000000;
    cmd_data = 16'h0000;
    guard_en = 1'b0;
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    // Program then read back
    run(fnh_pkg::OP_PROG, 22'h010020, 16'h0012);
    chk("prog error", 16'h0000, {15'h0, err_s});
    chk("prog count", 16'h0001, prog_cnt);
    chk("prog writes", 16'h0004, wr_cnt);
    run(fnh_pkg::OP_READ, 22'h010020, 16'h0000);
    chk("array read", 16'h0012, rd_s);
    $display("test program finished");
    // Identification codes, then exit
    run(fnh_pkg::OP_IDENT, 22'h000000, 16'h0000);
    chk("ident mode", {14'h0, fnh_pkg::MODE_IDENT}, {14'h0, mode});
    run(fnh_pkg::OP_READ, 22'h000000, 16'h0000);
    chk("maker code", 16'h00C3, rd_s);
    run(fnh_pkg::OP_READ, 22'h000001, 16'h0000);
    chk("device code", 16'h7A11, rd_s);
    run(fnh_pkg::OP_EXIT, 22'h000000, 16'h0000);
    chk("exit mode", {14'h0, fnh_pkg::MODE_ARRAY}, {14'h0, dev_mode});
    $display("test ident finished");
    // Query table and security identifier modes
    run(fnh_pkg::OP_QUERY, 22'h000000, 16'h0000);
    chk("query mode", {14'h0, fnh_pkg::MODE_QUERY}, {14'h0, dev_mode});
    run(fnh_pkg::OP_EXIT, 22'h000000, 16'h0000);
    run(fnh_pkg::OP_SECID, 22'h000000, 16'h0000);
    chk("secid mode", {14'h0, fnh_pkg::MODE_SECID}, {14'h0, dev_mode});
    run(fnh_pkg::OP_EXIT, 22'h000000, 16'h0000);
    chk("host mode", {14'h0, fnh_pkg::MODE_ARRAY}, {14'h0, mode});
    $display("test modes finished");
    // Guarded boot block: refused, nothing on the pins
    @(posedge clk);
    guard_en <= 1'b1;
    w0 = wr_cnt;
    run(fnh_pkg::OP_PROG, 22'h007FFF, 16'h0034);
    chk("boot prog refused", 16'h0001, {15'h0, err_s});
    run(fnh_pkg::OP_CERASE, 22'h000000, 16'h0000);
    chk("chip erase refused", 16'h0001, {15'h0, err_s});
    chk("no guarded writes", w0, wr_cnt);
    run(fnh_pkg::OP_PROG, 22'h008000, 16'h0056);
    chk("edge prog allowed", 16'h0000, {15'h0, err_s});
    @(posedge clk);
    guard_en <= 1'b0;
    $display("test guard finished");
    // Sector erase: six writes, then polled
    w0 = wr_cnt;
    run(fnh_pkg::OP_SERASE, 22'h012800, 16'h0000);
    chk("erase error", 16'h0000, {15'h0, err_s});
    chk("erase writes", 16'h0006, wr_cnt - w0);
    chk("erase count", 16'h0001, erase_cnt);
    run(fnh_pkg::OP_SUSP, 22'h012800, 16'h0000);
    chk("suspend status", 16'h00C0, rd_s & 16'h00C0);
    run(fnh_pkg::OP_RESUME, 22'h012800, 16'h0000);
    chk("resume error", 16'h0000, {15'h0, err_s});
    $display("test erase finished");
    // Security identifier program and lock-out
    run(fnh_pkg::OP_SPROG, 22'h000003, 16'h005A);
    chk("sec prog", 16'h0000, {15'h0, err_s});
    run(fnh_pkg::OP_SLOCK, 22'h000000, 16'h0000);
    chk("sec lock", 16'h0000, {15'h0, err_s});
    run(fnh_pkg::OP_SPROG, 22'h000003, 16'h00A5);
    chk("sec prog locked", 16'h0001, {15'h0, err_s});
    $display("test security finished");
    // Hard reset out of identification mode
    run(fnh_pkg::OP_IDENT, 22'h000000, 16'h0000);
    w0 = rst_cnt;
    run(fnh_pkg::OP_RESET, 22'h000000, 16'h0000);
    chk("reset pulse", w0 + 16'h0001, rst_cnt);
    chk("reset mode", {14'h0, fnh_pkg::MODE_ARRAY}, {14'h0, mode});
    run(fnh_pkg::OP_READ, 22'h010020, 16'h0000);
    chk("read after reset", 16'h0012, rd_s);
    $display("test reset finished");
    wrap_up();
  end
endmodule
